/* File: src/audio_port_regs.svh */
// register offsets, reset values and sizes of the audio port slot logic
`ifndef AUDIO_PORT_REGS_SVH
`define AUDIO_PORT_REGS_SVH
`define CTRL_OFS 8'h00
`define PIN_OFS 8'h04
`define STAT_OFS 8'h08
`define TXM_LO_OFS 8'h0C
`define TXM_HI_OFS 8'h10
`define RXM_LO_OFS 8'h14
`define RXM_HI_OFS 8'h18
`define NULL_OFS 8'h1C
`define TXH_OFS 8'h20
`define TXH_SPAN 8'h18
`define RXD_OFS 8'h40
`define RXD_SPAN 8'h10
`define MASK_RST 32'hFFFFFFFF
`define CTRL_RST 32'h00000000
`define CTRL_WMASK 32'h1FFFFFFF
`define PIN_RST 4'h0
`define N_TX 6
`define N_RX 4
`endif

/* File: src/audio_port_pkg.sv */
// types shared by the audio port slot logic
package audio_port_pkg;
  typedef struct packed {
    logic [2:0] unused;
    logic tx_even_irq_enable;
    logic tx_irq_enable;
    logic tx_last_slot_irq_enable;
    logic tx_exception_irq_enable;
    logic rx_last_slot_irq_enable;
    logic rx_irq_enable;
    logic rx_even_irq_enable;
    logic rx_exception_irq_enable;
    logic [3:0] rx_channel_enables;
    logic [5:0] tx_channel_enables;
    logic [4:0] bits_m1;
    logic [4:0] slots_m1;
    logic net_mode;
  } ctrl_t;
  typedef struct packed {
    logic tx_last;
    logic rx_last;
    logic tx_even;
    logic tx_underrun_flag;
    logic tx_empty_flag;
    logic rx_even_slot_flag;
    logic rx_overrun_flag;
    logic rx_full_flag;
  } flags_t;
  typedef struct packed {
    logic rx_exc;
    logic rx_even;
    logic rx_data;
    logic rx_last;
    logic tx_exc;
    logic tx_last;
    logic tx_even;
    logic tx_data;
  } irq_vec_t;
  typedef struct packed {
    logic start;
    logic bit_tick;
    logic slot_end;
    logic frame_end;
    logic last_start;
    logic [4:0] slot;
    logic [4:0] end_slot;
  } slot_evt_t;
  typedef enum {FR_IDLE, FR_RUN} frame_st_t;
endpackage

/* File: src/pin_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_s
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      pin_s <= '0;
    end else begin
      meta_q <= pin_in;
      pin_s <= meta_q;
    end
  end
endmodule

/* File: src/slot_timer.sv */
// bit and slot counter driven by the sampled bit clock and frame sync
`timescale 1ns/1ns
module slot_timer (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic bclk_rise,
  input wire logic fs_lvl,
  input wire logic [4:0] last_slot,
  input wire logic [4:0] bits_m1,
  output audio_port_pkg::slot_evt_t evt
);
  import audio_port_pkg::*;
  frame_st_t st_q;
  logic fs_prev_q;
  logic [4:0] bit_q;
  logic [4:0] slot_q;
  wire fs_lead = bclk_rise & fs_lvl & ~fs_prev_q;
  wire bit_last = bit_q == bits_m1;
  wire slot_last = slot_q == last_slot;
  wire [4:0] slot_nx = slot_q + 5'h01;

  // frame sync is seen one bit before the first data bit of slot 0
  always_ff @(posedge ref_clk) begin
    if (sys_rst | ~run) begin
      st_q <= FR_IDLE;
      fs_prev_q <= 1'b0;
      bit_q <= 5'h00;
      slot_q <= 5'h00;
      evt <= '0;
    end else begin
      evt <= '0;
      if (bclk_rise) begin
        fs_prev_q <= fs_lvl;
      end
      case (st_q)
        FR_IDLE: begin
          if (fs_lead) begin
            st_q <= FR_RUN;
            bit_q <= 5'h00;
            slot_q <= 5'h00;
            evt.start <= 1'b1;
            evt.slot <= 5'h00;
            evt.last_start <= last_slot == 5'h00;
          end
        end
        FR_RUN: begin
          if (bclk_rise) begin
            evt.bit_tick <= 1'b1;
            if (bit_last) begin
              bit_q <= 5'h00;
              evt.slot_end <= 1'b1;
              evt.end_slot <= slot_q;
              if (slot_last) begin
                evt.frame_end <= 1'b1;
                st_q <= FR_IDLE;
              end else begin
                slot_q <= slot_nx;
                evt.start <= 1'b1;
                evt.slot <= slot_nx;
                evt.last_start <= slot_nx == last_slot;
              end
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end
        end
        default: st_q <= FR_IDLE;
      endcase
    end
  end
endmodule

/* File: src/audio_port_slot_mask_irq.sv */
// slot masking, port reset and interrupt requests of a multi-slot audio port
`timescale 1ns/1ns
`include "audio_port_regs.svh"
module audio_port_slot_mask_irq (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bit_clk,
  input wire logic frame_sync,
  input wire logic [3:0] rx_pin,
  output logic [5:0] tx_pin,
  output logic [5:0] tx_oe_n,
  output audio_port_pkg::irq_vec_t irq_req
);
  import audio_port_pkg::*;

  // ==========================================================
  // pin sampling and slot timing
  logic [5:0] pin_s;
  logic bclk_d_q;
  slot_evt_t evt;
  ctrl_t ctrl_q;
  logic [3:0] pin_q;
  wire active = |pin_q;
  wire bclk_s = pin_s[5];
  wire fs_s = pin_s[4];
  wire [3:0] rx_s = pin_s[3:0];
  wire bclk_rise = bclk_s & ~bclk_d_q;
  wire [4:0] last_slot = ctrl_q.net_mode ? ctrl_q.slots_m1 : 5'h00;

  pin_sync #(.W(6)) u_pin_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({bit_clk, frame_sync, rx_pin}),
    .pin_s(pin_s)
  );

  slot_timer u_slot_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(active),
    .bclk_rise(bclk_rise),
    .fs_lvl(fs_s),
    .last_slot(last_slot),
    .bits_m1(ctrl_q.bits_m1),
    .evt(evt)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bclk_d_q <= 1'b0;
    end else begin
      bclk_d_q <= bclk_s;
    end
  end

  // ==========================================================
  // bus decode
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] a_q;
  logic [31:0] txm_q;
  logic [31:0] rxm_q;
  logic [31:0] txm_act_q;
  logic [31:0] rxm_act_q;
  flags_t fl_q;
  logic [23:0] txh_q [`N_TX];
  logic [23:0] txs_q [`N_TX];
  logic [23:0] rxs_q [`N_RX];
  logic [23:0] rxd_q [`N_RX];
  logic [5:0] tx_fresh_q;
  logic [5:0] tx_wr_q;
  logic [3:0] rx_rd_q;
  logic tx_arm_q;
  logic rx_arm_q;
  logic null_pend_q;
  logic drive_q;

  wire acc = hsel & hready & htrans[1];
  wire [7:0] tx_rel = a_q - `TXH_OFS;
  wire [7:0] rx_rel = a_q - `RXD_OFS;
  wire tx_hit_a = tx_rel < `TXH_SPAN;
  wire rx_hit_a = rx_rel < `RXD_SPAN;
  wire [2:0] tx_idx = tx_rel[4:2];
  wire [1:0] rx_idx = rx_rel[3:2];
  wire ctrl_wr = wr_pend_q & (a_q == `CTRL_OFS);
  wire pin_wr = wr_pend_q & (a_q == `PIN_OFS);
  wire txlo_wr = wr_pend_q & (a_q == `TXM_LO_OFS);
  wire txhi_wr = wr_pend_q & (a_q == `TXM_HI_OFS);
  wire rxlo_wr = wr_pend_q & (a_q == `RXM_LO_OFS);
  wire rxhi_wr = wr_pend_q & (a_q == `RXM_HI_OFS);
  wire null_wr = wr_pend_q & (a_q == `NULL_OFS) & active;
  wire tx_hit = wr_pend_q & tx_hit_a;
  wire rx_hit = rd_pend_q & rx_hit_a & active;
  wire st_rd = rd_pend_q & (a_q == `STAT_OFS);

  // ==========================================================
  // write and read completion tracking
  wire [5:0] tx_wr_now = tx_hit ? 6'h01 << tx_idx : 6'h00;
  wire [3:0] rx_rd_now = rx_hit ? 4'h1 << rx_idx : 4'h0;
  wire [5:0] tx_seen = tx_wr_q | tx_wr_now;
  wire [3:0] rx_seen = rx_rd_q | rx_rd_now;
  wire [5:0] tx_en = ctrl_q.tx_channel_enables;
  wire [3:0] rx_en = ctrl_q.rx_channel_enables;
  wire tx_all = tx_hit & ((tx_seen & tx_en) == tx_en);
  wire rx_all = rx_hit & ((rx_seen & rx_en) == rx_en);
  wire tx_done = tx_all | null_wr;

  // ==========================================================
  // slot events
  wire frame_first = evt.start & (evt.slot == 5'h00);
  wire [31:0] tx_cur = frame_first ? txm_q : txm_act_q;
  wire tx_load = evt.start & active;
  wire tx_mbit = tx_cur[evt.slot];
  wire tx_empty_set = tx_load & tx_mbit;
  wire tx_starved = |(tx_en & ~tx_fresh_q);
  wire und_set = tx_empty_set & ~null_pend_q & tx_starved;
  wire rx_xfer = evt.slot_end & active & rxm_act_q[evt.end_slot];
  wire net_on = ctrl_q.net_mode & active;
  wire drive_d = ~active ? 1'b0 : tx_load ? tx_mbit & ~null_pend_q : evt.frame_end ? 1'b0 : drive_q;

  // flags: a set in the same cycle as its clear wins
  wire tl_d = (evt.last_start & net_on) | (fl_q.tx_last & ~st_rd);
  wire rl_d = (evt.frame_end & net_on) | (fl_q.rx_last & ~st_rd);
  wire te_d = tx_empty_set | (fl_q.tx_empty_flag & ~tx_done);
  wire tv_d = tx_empty_set ? ~evt.slot[0] : fl_q.tx_even & ~tx_done;
  wire tu_d = und_set | (fl_q.tx_underrun_flag & ~(tx_done & tx_arm_q));
  wire rf_d = rx_xfer | (fl_q.rx_full_flag & ~rx_all);
  wire rv_d = rx_xfer ? ~evt.end_slot[0] : fl_q.rx_even_slot_flag & ~rx_all;
  wire ro_d = (rx_xfer & fl_q.rx_full_flag) | (fl_q.rx_overrun_flag & ~(rx_all & rx_arm_q));
  wire [7:0] fl_d = {tl_d, rl_d, tv_d, tu_d, te_d, rv_d, ro_d, rf_d};

  // ==========================================================
  // interrupt requests
  wire rx_exc = ctrl_q.rx_exception_irq_enable & fl_q.rx_full_flag & fl_q.rx_overrun_flag;
  wire rx_evn = ctrl_q.rx_even_irq_enable & fl_q.rx_full_flag & fl_q.rx_even_slot_flag;
  wire tx_exc = ctrl_q.tx_exception_irq_enable & fl_q.tx_empty_flag & fl_q.tx_underrun_flag;
  wire tx_evn = ctrl_q.tx_even_irq_enable & fl_q.tx_empty_flag & fl_q.tx_even;
  irq_vec_t irq_d;
  assign irq_d.rx_exc = rx_exc;
  assign irq_d.rx_even = rx_evn & ~rx_exc;
  assign irq_d.rx_data = ctrl_q.rx_irq_enable & fl_q.rx_full_flag & ~rx_exc & ~rx_evn;
  assign irq_d.rx_last = ctrl_q.rx_last_slot_irq_enable & fl_q.rx_last;
  assign irq_d.tx_exc = tx_exc;
  assign irq_d.tx_last = ctrl_q.tx_last_slot_irq_enable & fl_q.tx_last;
  assign irq_d.tx_even = tx_evn & ~tx_exc;
  assign irq_d.tx_data = ctrl_q.tx_irq_enable & fl_q.tx_empty_flag & ~tx_exc & ~tx_evn;

  // ==========================================================
  // read data; data registers read as zero while the port is idle
  wire [31:0] rd_val =
    (a_q == `CTRL_OFS) ? ctrl_q :
    (a_q == `PIN_OFS) ? {28'h0000000, pin_q} :
    (a_q == `STAT_OFS) ? {16'h0000, irq_req, fl_q} :
    (a_q == `TXM_LO_OFS) ? {16'h0000, txm_q[15:0]} :
    (a_q == `TXM_HI_OFS) ? {16'h0000, txm_q[31:16]} :
    (a_q == `RXM_LO_OFS) ? {16'h0000, rxm_q[15:0]} :
    (a_q == `RXM_HI_OFS) ? {16'h0000, rxm_q[31:16]} :
    rx_hit_a & active ? {8'h00, rxd_q[rx_idx]} : 32'h00000000;

  // ==========================================================
  // bus slave: writes without wait, reads with one wait state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      a_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= acc & hwrite;
      rd_pend_q <= acc & ~hwrite;
      hreadyout <= ~(acc & ~hwrite);
      hresp <= 1'b0;
      if (acc) begin
        a_q <= haddr[7:0];
      end
      if (rd_pend_q) begin
        hrdata <= rd_val;
      end
    end
  end

  // ==========================================================
  // control and mask registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RST;
      pin_q <= `PIN_RST;
      txm_q <= `MASK_RST;
      rxm_q <= `MASK_RST;
      txm_act_q <= `MASK_RST;
      rxm_act_q <= `MASK_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= hwdata & `CTRL_WMASK;
      end
      if (pin_wr) begin
        pin_q <= hwdata[3:0];
      end
      if (txlo_wr) begin
        txm_q[15:0] <= hwdata[15:0];
      end
      if (txhi_wr) begin
        txm_q[31:16] <= hwdata[15:0];
      end
      if (rxlo_wr) begin
        rxm_q[15:0] <= hwdata[15:0];
      end
      if (rxhi_wr) begin
        rxm_q[31:16] <= hwdata[15:0];
      end
      if (frame_first) begin
        txm_act_q <= txm_q;
        rxm_act_q <= rxm_q;
      end
    end
  end

  // ==========================================================
  // status flags and request outputs; all cleared while idle
  always_ff @(posedge ref_clk) begin
    if (sys_rst | ~active) begin
      fl_q <= '0;
      irq_req <= '0;
      tx_wr_q <= 6'h00;
      rx_rd_q <= 4'h0;
      tx_arm_q <= 1'b0;
      rx_arm_q <= 1'b0;
      null_pend_q <= 1'b0;
      drive_q <= 1'b0;
      tx_oe_n <= 6'h3F;
    end else begin
      fl_q <= fl_d;
      irq_req <= irq_d;
      tx_wr_q <= tx_done ? 6'h00 : tx_seen;
      rx_rd_q <= rx_all ? 4'h0 : rx_seen;
      tx_arm_q <= (st_rd & fl_q.tx_underrun_flag) | (tx_arm_q & ~tx_done);
      rx_arm_q <= (st_rd & fl_q.rx_overrun_flag) | (rx_arm_q & ~rx_all);
      null_pend_q <= null_wr | (null_pend_q & ~tx_load);
      drive_q <= drive_d;
      tx_oe_n <= ~({6{drive_d}} & tx_en);
    end
  end

  // ==========================================================
  // transmit holding and shift registers
  // masked slots still move holding data, so a late write waits for the next open slot
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_fresh_q <= 6'h00;
      tx_pin <= 6'h00;
      for (int i = 0; i < `N_TX; i++) begin
        txh_q[i] <= 24'h000000;
        txs_q[i] <= 24'h000000;
      end
    end else begin
      tx_fresh_q <= tx_wr_now | (tx_fresh_q & ~{6{tx_load}});
      for (int i = 0; i < `N_TX; i++) begin
        if (tx_wr_now[i]) begin
          txh_q[i] <= hwdata[23:0];
        end
        if (tx_load) begin
          txs_q[i] <= txh_q[i];
          tx_pin[i] <= txh_q[i][23];
        end else if (evt.bit_tick) begin
          txs_q[i] <= {txs_q[i][22:0], 1'b0};
          tx_pin[i] <= txs_q[i][22];
        end
      end
    end
  end

  // ==========================================================
  // receive shift and data registers
  // shifters run for every slot; a receiver enabled mid-stream stores a complete first word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `N_RX; i++) begin
        rxs_q[i] <= 24'h000000;
        rxd_q[i] <= 24'h000000;
      end
    end else begin
      for (int i = 0; i < `N_RX; i++) begin
        if (evt.bit_tick & active) begin
          rxs_q[i] <= {rxs_q[i][22:0], rx_s[i]};
        end
        if (rx_xfer & rx_en[i]) begin
          rxd_q[i] <= {rxs_q[i][22:0], rx_s[i]};
        end
      end
    end
  end
endmodule

/* File: dv/apsmi_checker_properties.sv */
// timing and priority properties of the audio port slot logic ports
`timescale 1ns/1ns
`include "audio_port_regs.svh"
module apsmi_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic bit_clk,
  input wire logic [5:0] tx_pin,
  input wire logic [5:0] tx_oe_n,
  input audio_port_pkg::irq_vec_t irq_req
);
  import audio_port_pkg::*;
  // ==========================================
  // helper logic
  logic [2:0] bclk_q;
  logic [3:0] since_rise_q;
  logic pin_wr_q;
  logic pin_zero_q;
  wire bclk_rise = bclk_q[1] & ~bclk_q[2];
  wire pin_addr = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == `PIN_OFS);
  wire [3:0] since_sat = (since_rise_q == 4'hF) ? 4'hF : since_rise_q + 4'h1;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bclk_q <= 3'h0;
      since_rise_q <= 4'hF;
      pin_wr_q <= 1'b0;
      pin_zero_q <= 1'b1;
    end else begin
      bclk_q <= {bclk_q[1:0], bit_clk};
      since_rise_q <= bclk_rise ? 4'h0 : since_sat;
      pin_wr_q <= pin_addr;
      if (pin_wr_q) pin_zero_q <= (hwdata[3:0] == 4'h0);
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_read_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_READ_ONE_WAIT: assert property (s_read_taken |=> s_one_wait)
    else $error("read wait state wrong");
  AST_WRITE_NO_WAIT: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_RESET_IDLE: assert property ($fell(sys_rst) |-> tx_oe_n == 6'h3F && irq_req == 8'h00)
    else $error("outputs not idle after reset");
  AST_RX_PRIORITY: assert property ($onehot0({irq_req.rx_exc, irq_req.rx_even, irq_req.rx_data}))
    else $error("receive requests not prioritised");
  AST_TX_PRIORITY: assert property ($onehot0({irq_req.tx_exc, irq_req.tx_even, irq_req.tx_data}))
    else $error("transmit requests not prioritised");
  AST_IDLE_QUIET: assert property (pin_zero_q && $past(pin_zero_q, 3) |-> tx_oe_n == 6'h3F && irq_req == 8'h00)
    else $error("port active with no pin assigned");
  AST_PIN_AFTER_RISE: assert property ($changed(tx_pin) |-> since_rise_q <= 4'd6 || pin_zero_q)
    else $error("tx data changed away from a bit clock rise");
  AST_OE_AFTER_RISE: assert property ($changed(tx_oe_n) |-> since_rise_q <= 4'd6 || pin_zero_q)
    else $error("tx enable changed away from a bit clock rise");
  AST_TX_LAST_AT_SLOT: assert property ($rose(irq_req.tx_last) |-> since_rise_q <= 4'd6)
    else $error("tx last slot request off slot start");
  AST_RX_EXC_AT_SLOT: assert property ($rose(irq_req.rx_exc) |-> since_rise_q <= 4'd6)
    else $error("rx exception request off slot end");
endmodule
bind audio_port_slot_mask_irq apsmi_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .bit_clk(bit_clk), .tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .irq_req(irq_req));

/* File: dv/link_partner.sv */
// codec side of the tdm link: bit clock, frame sync, rx data, tx capture
`timescale 1ns/1ns
module link_partner #(
  parameter int SLOTS = 4,
  parameter int BITS = 24
) (
  input wire logic go,
  input wire logic [5:0] tx_pin,
  input wire logic [5:0] tx_oe_n,
  output logic bit_clk,
  output logic frame_sync,
  output logic [3:0] rx_pin,
  output logic busy,
  output logic [SLOTS-1:0][BITS-1:0] tx_cap,
  output logic [SLOTS-1:0] tx_drv
);
  logic [23:0] w;
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
    rx_pin = 4'hF;
    busy = 1'b0;
    tx_cap = '0;
    tx_drv = '0;
  end
  // ==========================================
  // one frame per go; bit clock stands still between frames
  always @(posedge go) begin
    busy = 1'b1;
    tx_drv = '1;
    frame_sync = 1'b1;
    #20;
    for (int k = 0; k <= SLOTS * BITS; k++) begin
      bit_clk = 1'b1;
      #40;
      bit_clk = 1'b0;
      frame_sync = 1'b0;
      w = {8'h5A, 8'(k / BITS), 8'hC3};
      if (k < SLOTS * BITS) rx_pin = {4{w[BITS-1-k%BITS]}};
      #35;
      if (k < SLOTS * BITS) begin
        tx_cap[k/BITS][BITS-1-k%BITS] = tx_pin[0];
        if (tx_oe_n[0] !== 1'b0) tx_drv[k/BITS] = 1'b0;
      end
      #5;
    end
    rx_pin = ~rx_pin;
    busy = 1'b0;
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench of the audio port slot mask and request logic
`timescale 1ns/1ns
`include "audio_port_regs.svh"
module tb_top;
  import audio_port_pkg::*;
  localparam logic [31:0] CTRL_VAL = 32'h0FA20DC7;
  localparam logic [31:0] TX_WORD = 32'h00123456;
  localparam logic [31:0] RX_SLOT1 = 32'h005A01C3;
  logic ref_clk, sys_rst, hsel, hwrite, go, hreadyout, hresp, bit_clk, frame_sync, busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [3:0] rx_pin, tx_drv;
  logic [5:0] tx_pin, tx_oe_n;
  logic [3:0][23:0] tx_cap;
  logic [7:0] ra [8] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h00, 8'h04, 8'h08, 8'h60};
  irq_vec_t irq_req;
  int n_mismatch, checks_done;
  wire hready = hreadyout;
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  audio_port_slot_mask_irq DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bit_clk(bit_clk), .frame_sync(frame_sync), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .irq_req(irq_req));
  link_partner link (.go(go), .tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .bit_clk(bit_clk),
    .frame_sync(frame_sync), .rx_pin(rx_pin), .busy(busy), .tx_cap(tx_cap), .tx_drv(tx_drv));
  // ==========================================
  // bus and check tasks
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic run_frame(input logic mid);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    if (mid) begin
      while (tx_oe_n[0] !== 1'b0) @(posedge ref_clk);
      xfer(1'b1, `TXM_LO_OFS, 32'h0000FFFF);
      xfer(1'b1, `TXM_HI_OFS, 32'h0000FFFF);
      xfer(1'b1, `RXM_LO_OFS, 32'h0000FFFF);
      xfer(1'b1, `RXM_HI_OFS, 32'h0000FFFF);
      rd_chk(`TXM_LO_OFS, 32'hFFFFFFFF, 32'h0000FFFF);
      rd_chk(`RXM_HI_OFS, 32'hFFFFFFFF, 32'h0000FFFF);
    end
    while (busy !== 1'b0) @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    go = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(ra[i], 32'hFFFFFFFF, (i < 4) ? 32'h0000FFFF : 32'h0);
    $display("test reset_values done");
    xfer(1'b1, `CTRL_OFS, CTRL_VAL);
    xfer(1'b1, `TXM_LO_OFS, 32'h00000005);
    xfer(1'b1, `TXM_HI_OFS, 32'h0);
    xfer(1'b1, `RXM_LO_OFS, 32'h00000002);
    xfer(1'b1, `RXM_HI_OFS, 32'h0);
    xfer(1'b1, `TXH_OFS, TX_WORD);
    xfer(1'b1, `PIN_OFS, 32'h1);
    run_frame(1'b0);
    chk({8'h0, tx_cap[0]}, TX_WORD);
    chk({8'h0, tx_cap[2]}, TX_WORD);
    chk({28'h0, tx_drv}, 32'h5);
    rd_chk(`STAT_OFS, 32'h0000E9FF, 32'h000028F9);
    rd_chk(`RXD_OFS, 32'h00FFFFFF, RX_SLOT1);
    xfer(1'b1, `TXH_OFS, TX_WORD);
    $display("test masked_frame done");
    run_frame(1'b1);
    chk({28'h0, tx_drv}, 32'h5);
    xfer(1'b0, `STAT_OFS, 32'h0);
    rd_chk(`RXD_OFS, 32'h00FFFFFF, RX_SLOT1);
    xfer(1'b1, `NULL_OFS, 32'h0);
    run_frame(1'b0);
    chk({28'h0, tx_drv}, 32'hE);
    rd_chk(`STAT_OFS, 32'h00008003, 32'h00008003);
    $display("test mask_update done");
    xfer(1'b1, `PIN_OFS, 32'h0);
    rd_chk(`STAT_OFS, 32'hFFFFFFFF, 32'h0);
    rd_chk(`CTRL_OFS, 32'hFFFFFFFF, CTRL_VAL);
    rd_chk(`TXM_LO_OFS, 32'hFFFFFFFF, 32'h0000FFFF);
    chk({24'h0, irq_req}, 32'h0);
    $display("test port_idle done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
